//--- hdl/pulse_beat_defines.svh
// What this block does
// - Polarity bit passes pulse input unchanged at 0, inverts at 1; resets 0.
// - Derivative-disable bit enables differentiator at 0, bypasses it at 1.
// - Three-bit gain field, reset 000, selects pulse gain, independent of monitor mode.
// - Monitor select 00 disables buffer, 01 routes amplifier, 10 routes gain stage.
// - Bandwidth-limit bit picks full or limited bandwidth, only when monitor on.
// - Positive threshold code, reset 0101, times 22.5 step.
// - Negative threshold code, reset 0101, negated times same step.
// - Beat config is two read/write registers: gain low, timing high.
// - Window field, reset 0011, gives six steps plus two per code; codes above 1011 clamp to 28 steps.
// - Beat gain field, reset 1111, scales input by two to the field.
// - Pulse config changes may break output sync; resync command restores it.
// - Beat detection runs only when its enable and biopotential enable are set.
`ifndef PULSE_BEAT_DEFINES_SVH
`define PULSE_BEAT_DEFINES_SVH
`define ADDR_PULSE_CFG 5'h1a
`define ADDR_BEAT_GAIN 5'h1d
`define ADDR_BEAT_TIMING 5'h1e
`define PULSE_CFG_MASK 24'h8f70ff
`define PULSE_CFG_RESET 24'h000055
`define BEAT_GAIN_MASK 24'hffbf00
`define BEAT_GAIN_RESET 24'h3f2300
`define BEAT_TIMING_MASK 24'h3f3700
`define BEAT_TIMING_RESET 24'h202200
`define BIT_POL 23
`define BIT_DERIV_DIS 19
`define GAIN_HI 18
`define GAIN_LO 16
`define BIT_LBW 14
`define MON_HI 13
`define MON_LO 12
`define DACP_HI 7
`define DACP_LO 4
`define DACN_HI 3
`define DACN_LO 0
`define WIN_HI 23
`define WIN_LO 20
`define BGAIN_HI 19
`define BGAIN_LO 16
`define BIT_BEAT_EN 15
`define WIN_BASE 5'h06
`define WIN_MAX 4'hb
`define WIN_TOP 5'h1c
`endif

//--- hdl/pulse_beat_pkg.sv
package pulse_beat_pkg;
  typedef enum logic [1:0] {MON_OFF, MON_INA, MON_PGA, MON_RSVD} monitor_sel_t;
endpackage : pulse_beat_pkg

//--- hdl/pulse_and_beat_config.sv
`timescale 1ns/1ps
`default_nettype none
`include "pulse_beat_defines.svh"
module pulse_and_beat_config #(
  parameter int ADDR_W = 5
) (
  input wire logic mclk,
  input wire logic resetn,
  input wire logic [ADDR_W-1:0] addr,
  input wire logic [23:0] wdata,
  input wire logic wr_stb,
  input wire logic rd_stb,
  output logic [23:0] rdata,
  input wire logic pulse_in,
  input wire logic biopotential_en,
  input wire logic resync_command,
  output logic pulse_out,
  output logic derivative_disable,
  output logic [2:0] pulse_gain,
  output logic [1:0] monitor_out_sel,
  output logic monitor_bw_limit,
  output logic [3:0] pos_threshold_code,
  output logic [3:0] neg_threshold_code,
  output logic [4:0] window_steps,
  output logic [3:0] beat_gain_exp,
  output logic beat_detect_run,
  output logic resync_pulse
);
  // ==========================================
  // Register storage
  logic [23:0] pulse_cfg_reg;
  logic [23:0] beat_gain_reg;
  logic [23:0] beat_timing_reg;
  logic [23:0] rdata_reg;
  logic [1:0] pulse_sync_reg;
  logic [1:0] bio_sync_reg;
  logic [1:0] rsy_sync_reg;
  logic rsy_prev_reg;
  logic resync_reg;
  logic pulse_out_reg;
  logic [4:0] steps_reg;
  logic run_reg;
  logic mon_bw_reg;

  wire sel_pulse = (addr == ADDR_W'(`ADDR_PULSE_CFG));
  wire sel_gain = (addr == ADDR_W'(`ADDR_BEAT_GAIN));
  wire sel_timing = (addr == ADDR_W'(`ADDR_BEAT_TIMING));
  wire [23:0] pulse_cfg_next = wdata & `PULSE_CFG_MASK;
  wire [23:0] beat_gain_next = wdata & `BEAT_GAIN_MASK;
  wire [23:0] beat_timing_next = wdata & `BEAT_TIMING_MASK;
  wire [23:0] rdata_next = sel_pulse ? pulse_cfg_reg :
                           sel_gain ? beat_gain_reg :
                           sel_timing ? beat_timing_reg : 24'h000000;

  // ==========================================
  // Window decode
  // Reserved window codes are left to software; clamping holds the output at
  // the widest legal window rather than letting it wrap past the top step
  function automatic logic [4:0] steps_of(input logic [3:0] code);
    logic [3:0] eff;
    eff = (code > `WIN_MAX) ? `WIN_MAX : code;
    return `WIN_BASE + {eff, 1'b0};
  endfunction : steps_of

  wire pol = pulse_cfg_reg[`BIT_POL];
  wire [1:0] mon = pulse_cfg_reg[`MON_HI:`MON_LO];
  wire mon_on = (mon != pulse_beat_pkg::MON_OFF);
  wire [3:0] win_code = beat_gain_reg[`WIN_HI:`WIN_LO];
  wire [4:0] steps_next = steps_of(win_code);

  // ==========================================
  // Bus slave
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      pulse_cfg_reg <= `PULSE_CFG_RESET;
      beat_gain_reg <= `BEAT_GAIN_RESET;
      beat_timing_reg <= `BEAT_TIMING_RESET;
      rdata_reg <= 24'h000000;
    end else begin
      if (wr_stb && sel_pulse) pulse_cfg_reg <= pulse_cfg_next;
      if (wr_stb && sel_gain) beat_gain_reg <= beat_gain_next;
      if (wr_stb && sel_timing) beat_timing_reg <= beat_timing_next;
      rdata_reg <= rd_stb ? rdata_next : 24'h000000;
    end
  end

  // ==========================================
  // Synchronisers and derived controls
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      pulse_sync_reg <= 2'h0;
      bio_sync_reg <= 2'h0;
      rsy_sync_reg <= 2'h0;
      rsy_prev_reg <= 1'b0;
      resync_reg <= 1'b0;
      pulse_out_reg <= 1'b0;
      steps_reg <= 5'h00;
      run_reg <= 1'b0;
      mon_bw_reg <= 1'b0;
    end else begin
      pulse_sync_reg <= {pulse_sync_reg[0], pulse_in};
      bio_sync_reg <= {bio_sync_reg[0], biopotential_en};
      rsy_sync_reg <= {rsy_sync_reg[0], resync_command};
      rsy_prev_reg <= rsy_sync_reg[1];
      resync_reg <= rsy_sync_reg[1] & ~rsy_prev_reg;
      pulse_out_reg <= pulse_sync_reg[1] ^ pol;
      steps_reg <= steps_next;
      run_reg <= beat_gain_reg[`BIT_BEAT_EN] & bio_sync_reg[1];
      mon_bw_reg <= mon_on & pulse_cfg_reg[`BIT_LBW];
    end
  end

  assign rdata = rdata_reg;
  assign pulse_out = pulse_out_reg;
  assign derivative_disable = pulse_cfg_reg[`BIT_DERIV_DIS];
  assign pulse_gain = pulse_cfg_reg[`GAIN_HI:`GAIN_LO];
  assign monitor_out_sel = mon;
  assign monitor_bw_limit = mon_bw_reg;
  assign pos_threshold_code = pulse_cfg_reg[`DACP_HI:`DACP_LO];
  assign neg_threshold_code = pulse_cfg_reg[`DACN_HI:`DACN_LO];
  assign window_steps = steps_reg;
  assign beat_gain_exp = beat_gain_reg[`BGAIN_HI:`BGAIN_LO];
  assign beat_detect_run = run_reg;
  assign resync_pulse = resync_reg;

  // ==========================================
  // Assertions
  sequence s_write_pulse;
    wr_stb && sel_pulse;
  endsequence

  sequence s_write_gain;
    wr_stb && sel_gain;
  endsequence

  sequence s_write_timing;
    wr_stb && sel_timing;
  endsequence

  sequence s_keep_pulse;
    !(wr_stb && sel_pulse);
  endsequence

  sequence s_keep_gain;
    !(wr_stb && sel_gain);
  endsequence

  sequence s_keep_timing;
    !(wr_stb && sel_timing);
  endsequence

  // Rise of the command as seen behind the synchroniser
  sequence s_sync_rise;
    rsy_sync_reg[1] && !rsy_prev_reg;
  endsequence

  // ==========================================
  // Pulse channel checks
  AST_POL: assert property (@(posedge mclk) disable iff (!resetn)
    s_write_pulse ##3 1'b1
    |-> pulse_out == ($past(pulse_sync_reg[1]) ^ $past(pol)))
    else $error("pulse polarity wrong");

  AST_DIFF: assert property (@(posedge mclk) disable iff (!resetn)
    s_write_pulse
    |=> derivative_disable == $past(wdata[`BIT_DERIV_DIS]))
    else $error("derivative bit not stored");

  AST_DIFF_HOLD: assert property (@(posedge mclk) disable iff (!resetn)
    s_keep_pulse
    |=> $stable(derivative_disable))
    else $error("derivative bit changed without a write");

  AST_GAIN: assert property (@(posedge mclk) disable iff (!resetn)
    s_write_pulse
    |=> pulse_gain == $past(wdata[`GAIN_HI:`GAIN_LO]))
    else $error("gain field not stored");

  AST_GAIN_HOLD: assert property (@(posedge mclk) disable iff (!resetn)
    s_keep_pulse
    |=> $stable(pulse_gain))
    else $error("gain field changed without a write");

  AST_MON: assert property (@(posedge mclk) disable iff (!resetn)
    s_write_pulse
    |=> monitor_out_sel == $past(wdata[`MON_HI:`MON_LO]))
    else $error("monitor select not stored");

  AST_MON_HOLD: assert property (@(posedge mclk) disable iff (!resetn)
    s_keep_pulse
    |=> $stable(monitor_out_sel))
    else $error("monitor select changed without a write");

  AST_LBW: assert property (@(posedge mclk) disable iff (!resetn)
    monitor_out_sel == 2'h0
    |=> !monitor_bw_limit)
    else $error("bandwidth limit active while monitor off");

  AST_LBW_ON: assert property (@(posedge mclk) disable iff (!resetn)
    monitor_out_sel != 2'h0
    |=> monitor_bw_limit == $past(pulse_cfg_reg[`BIT_LBW]))
    else $error("bandwidth limit does not follow its bit");

  AST_DACP: assert property (@(posedge mclk) disable iff (!resetn)
    s_write_pulse
    |=> pos_threshold_code == $past(wdata[`DACP_HI:`DACP_LO]))
    else $error("positive threshold not stored");

  AST_DACP_HOLD: assert property (@(posedge mclk) disable iff (!resetn)
    s_keep_pulse
    |=> $stable(pos_threshold_code))
    else $error("positive threshold changed without a write");

  AST_DACN: assert property (@(posedge mclk) disable iff (!resetn)
    s_write_pulse
    |=> neg_threshold_code == $past(wdata[`DACN_HI:`DACN_LO]))
    else $error("negative threshold not stored");

  AST_DACN_HOLD: assert property (@(posedge mclk) disable iff (!resetn)
    s_keep_pulse
    |=> $stable(neg_threshold_code))
    else $error("negative threshold changed without a write");

  AST_MASK: assert property (@(posedge mclk) disable iff (!resetn)
    1'b1
    |-> (pulse_cfg_reg & ~`PULSE_CFG_MASK) == 24'h000000)
    else $error("unused pulse bits set");

  AST_PULSE_STORE: assert property (@(posedge mclk) disable iff (!resetn)
    s_write_pulse
    |=> pulse_cfg_reg == ($past(wdata) & `PULSE_CFG_MASK))
    else $error("pulse register write not masked");

  // ==========================================
  // Beat detector checks
  AST_WIN: assert property (@(posedge mclk) disable iff (!resetn)
    wr_stb && sel_gain && wdata[`WIN_HI:`WIN_LO] == 4'h0 ##1 s_keep_gain
    |=> window_steps == `WIN_BASE)
    else $error("window steps wrong");

  AST_WIN_RANGE: assert property (@(posedge mclk) disable iff (!resetn)
    $past(resetn)
    |-> window_steps >= `WIN_BASE && window_steps <= `WIN_TOP)
    else $error("window steps out of range");

  AST_WIN_EVEN: assert property (@(posedge mclk) disable iff (!resetn)
    $past(resetn)
    |-> !window_steps[0])
    else $error("window steps odd");

  AST_BGAIN: assert property (@(posedge mclk) disable iff (!resetn)
    s_write_gain
    |=> beat_gain_exp == $past(wdata[`BGAIN_HI:`BGAIN_LO]))
    else $error("beat gain not stored");

  AST_BGAIN_HOLD: assert property (@(posedge mclk) disable iff (!resetn)
    s_keep_gain
    |=> $stable(beat_gain_exp))
    else $error("beat gain changed without a write");

  AST_RUN: assert property (@(posedge mclk) disable iff (!resetn)
    beat_detect_run
    |-> $past(bio_sync_reg[1]))
    else $error("beat detection runs without biopotential enable");

  AST_RUN_EN: assert property (@(posedge mclk) disable iff (!resetn)
    beat_detect_run
    |-> $past(beat_gain_reg[`BIT_BEAT_EN]))
    else $error("beat detection runs without its enable");

  AST_RUN_ON: assert property (@(posedge mclk) disable iff (!resetn)
    $past(resetn) && $past(beat_gain_reg[`BIT_BEAT_EN]) && $past(bio_sync_reg[1])
    |-> beat_detect_run)
    else $error("beat detection idle although both enables set");

  AST_RUN_BIO: assert property (@(posedge mclk) disable iff (!resetn)
    !bio_sync_reg[1]
    |=> !beat_detect_run)
    else $error("beat detection started without biopotential enable");

  AST_MASK_GAIN: assert property (@(posedge mclk) disable iff (!resetn)
    1'b1
    |-> (beat_gain_reg & ~`BEAT_GAIN_MASK) == 24'h000000)
    else $error("unused beat gain bits set");

  AST_GAIN_STORE: assert property (@(posedge mclk) disable iff (!resetn)
    s_write_gain
    |=> beat_gain_reg == ($past(wdata) & `BEAT_GAIN_MASK))
    else $error("beat gain register write not masked");

  // ==========================================
  // Bus and readback checks
  AST_READ: assert property (@(posedge mclk) disable iff (!resetn)
    rd_stb && sel_timing && !wr_stb
    |=> rdata == beat_timing_reg)
    else $error("timing readback wrong");

  AST_READ_PULSE: assert property (@(posedge mclk) disable iff (!resetn)
    rd_stb && sel_pulse
    |=> rdata == $past(pulse_cfg_reg))
    else $error("pulse readback wrong");

  AST_READ_GAIN: assert property (@(posedge mclk) disable iff (!resetn)
    rd_stb && sel_gain
    |=> rdata == $past(beat_gain_reg))
    else $error("beat gain readback wrong");

  AST_READ_UNMAPPED: assert property (@(posedge mclk) disable iff (!resetn)
    rd_stb && !sel_pulse && !sel_gain && !sel_timing
    |=> rdata == 24'h000000)
    else $error("unmapped read not zero");

  AST_RD_IDLE: assert property (@(posedge mclk) disable iff (!resetn)
    !rd_stb
    |=> rdata == 24'h000000)
    else $error("read data present without a read");

  AST_TIMING_STORE: assert property (@(posedge mclk) disable iff (!resetn)
    s_write_timing
    |=> beat_timing_reg == ($past(wdata) & `BEAT_TIMING_MASK))
    else $error("timing register write not masked");

  AST_TIMING_HOLD: assert property (@(posedge mclk) disable iff (!resetn)
    s_keep_timing
    |=> $stable(beat_timing_reg))
    else $error("timing register changed without a write");

  AST_MASK_TIMING: assert property (@(posedge mclk) disable iff (!resetn)
    1'b1
    |-> (beat_timing_reg & ~`BEAT_TIMING_MASK) == 24'h000000)
    else $error("unused timing bits set");

  // ==========================================
  // Resync checks
  AST_RESYNC: assert property (@(posedge mclk) disable iff (!resetn)
    resync_pulse
    |=> !resync_pulse)
    else $error("resync pulse longer than one cycle");

  AST_RESYNC_RISE: assert property (@(posedge mclk) disable iff (!resetn)
    s_sync_rise
    |=> resync_pulse)
    else $error("resync command rise gave no pulse");

  AST_RESYNC_SRC: assert property (@(posedge mclk) disable iff (!resetn)
    resync_pulse
    |-> $past(rsy_sync_reg[1]) && !$past(rsy_prev_reg))
    else $error("resync pulse without a command rise");
endmodule : pulse_and_beat_config
`default_nettype wire

//--- tb/testbench.sv
`timescale 1ns/1ps
`default_nettype none
module testbench;
  // ==========
  // Stimulus and observed signals
  logic mclk = 1'b0;
  logic resetn = 1'b0;
  logic [4:0] addr = 5'h00;
  logic [23:0] wdata = 24'h000000;
  logic wr_stb = 1'b0;
  logic rd_stb = 1'b0;
  logic pulse_in = 1'b0;
  logic biopotential_en = 1'b0;
  logic resync_command = 1'b0;
  logic [23:0] rdata;
  logic pulse_out, derivative_disable, monitor_bw_limit, beat_detect_run, resync_pulse;
  logic [2:0] pulse_gain;
  logic [1:0] monitor_out_sel;
  logic [3:0] pos_threshold_code, neg_threshold_code, beat_gain_exp;
  logic [4:0] window_steps;
  logic [23:0] v;
  int err_total = 0;
  int total_checks = 0;
  int seen;
  always #20 mclk = ~mclk;
  pulse_and_beat_config u_pulse_and_beat_config (.mclk(mclk), .resetn(resetn), .addr(addr), .wdata(wdata),
    .wr_stb(wr_stb), .rd_stb(rd_stb), .rdata(rdata), .pulse_in(pulse_in), .biopotential_en(biopotential_en),
    .resync_command(resync_command), .pulse_out(pulse_out), .derivative_disable(derivative_disable),
    .pulse_gain(pulse_gain), .monitor_out_sel(monitor_out_sel), .monitor_bw_limit(monitor_bw_limit),
    .pos_threshold_code(pos_threshold_code), .neg_threshold_code(neg_threshold_code),
    .window_steps(window_steps), .beat_gain_exp(beat_gain_exp), .beat_detect_run(beat_detect_run),
    .resync_pulse(resync_pulse));
  // ==========
  // Bus tasks and comparison
  task automatic chk(input logic [23:0] got, input logic [23:0] exp);
    total_checks++;
    if (got !== exp) begin
      err_total++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  function automatic logic [23:0] steps_for(input int code);
    return 24'(6 + 2 * code);
  endfunction : steps_for
  task automatic wr(input logic [4:0] a, input logic [23:0] d);
    @(posedge mclk);
    addr <= a;
    wdata <= d;
    wr_stb <= 1'b1;
    @(posedge mclk);
    wr_stb <= 1'b0;
  endtask : wr
  task automatic rd(input logic [4:0] a, input logic [23:0] exp);
    @(posedge mclk);
    addr <= a;
    rd_stb <= 1'b1;
    @(posedge mclk);
    rd_stb <= 1'b0;
    #1;
    chk(rdata, exp);
  endtask : rd
  // Pulse input passes two sync stages and an output register, so each level is held four edges
  task automatic chk_pulse(input logic [23:0] r);
    for (int p = 0; p < 2; p++) begin
      @(posedge mclk);
      pulse_in <= 1'(p);
      repeat (4) @(posedge mclk);
      #1;
      chk({23'h0, pulse_out}, {23'h0, 1'(p) ^ r[23]});
    end
    chk({23'h0, derivative_disable}, {23'h0, r[19]});
    chk({21'h0, pulse_gain}, {21'h0, r[18:16]});
    chk({22'h0, monitor_out_sel}, {22'h0, r[13:12]});
    chk({23'h0, monitor_bw_limit}, {23'h0, r[14] & (|r[13:12])});
    chk({16'h0, pos_threshold_code, neg_threshold_code}, {16'h0, r[7:0]});
  endtask : chk_pulse
  task automatic complete_run();
    $display("Checks %0d, errors %0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : complete_run
  // ==========
  // Main sequence
  initial begin
    void'($urandom(28183));
    repeat (20) @(posedge mclk);
    resetn <= 1'b1;
    rd(5'h1a, 24'h000055);
    rd(5'h1d, 24'h3f2300);
    rd(5'h1e, 24'h202200);
    chk_pulse(24'h000055);
    for (int i = 0; i < 12; i++) begin
      v = $urandom;
      v[13:12] = 2'($urandom_range(2, 0));
      // Corners: bandwidth bit with monitor off, then every writable bit set except monitor-select bit 12
      if (i < 2) v = (i == 0) ? 24'h7f4f00 : 24'hffefff;
      wr(5'h1a, v);
      rd(5'h1a, v & 24'h8f70ff);
      chk_pulse(v);
    end
    // Reserved window codes are never written
    for (int c = 0; c < 12; c++) begin
      @(posedge mclk);
      biopotential_en <= 1'($urandom);
      v = $urandom;
      v[23:20] = 4'(c);
      wr(5'h1d, v);
      rd(5'h1d, v & 24'hffbf00);
      @(posedge mclk);
      #1;
      chk({19'h0, window_steps}, steps_for(c));
      chk({20'h0, beat_gain_exp}, {20'h0, v[19:16]});
      chk({23'h0, beat_detect_run}, {23'h0, v[15] & biopotential_en});
    end
    wr(5'h1e, 24'hffffff);
    rd(5'h1e, 24'h3f3700);
    wr(5'h1f, 24'hffffff);
    rd(5'h1f, 24'h000000);
    rd(5'h00, 24'h000000);
    @(posedge mclk);
    resync_command <= 1'b1;
    seen = 0;
    repeat (8) begin
      @(posedge mclk);
      #1;
      seen += int'(resync_pulse === 1'b1);
    end
    chk(24'(seen), 24'h000001);
    resetn <= 1'b0;
    @(posedge mclk);
    resetn <= 1'b1;
    rd(5'h1a, 24'h000055);
    complete_run();
  end
  // Whole run needs well under 2000 cycles
  initial begin
    #(40 * 20000);
    err_total++;
    complete_run();
  end
endmodule : testbench
`default_nettype wire
